// File: verilog/ptc_params.svh
// Purpose: constants for the periodic timer core
// Assumes: AXI4-Lite word registers, byte data in bits 7:0
// Notes: What this block does is listed below
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_OFF_CTRL0 8'h00
`define PTC_OFF_CTRL1 8'h04
`define PTC_OFF_CNT_LO 8'h08
`define PTC_OFF_CNT_HI 8'h0C
`define PTC_OFF_CMPA_LO 8'h10
`define PTC_OFF_CMPA_HI 8'h14
`define PTC_OFF_CMPP_LO 8'h18
`define PTC_OFF_CMPP_HI 8'h1C
`define PTC_OFF_IRQ_STAT 8'h20
`define PTC_OFF_IRQ_MASK 8'h24
`define PTC_RESET_BYTE 8'h00
`define PTC_C0_HOLD 7
`define PTC_C0_CLK_HI 6
`define PTC_C0_CLK_LO 4
`define PTC_C0_RUN 3
`define PTC_C1_MODE_HI 7
`define PTC_C1_MODE_LO 6
`define PTC_C1_PIN_HI 5
`define PTC_C1_PIN_LO 4
`define PTC_C1_INIT 3
`define PTC_C1_INV 2
`define PTC_C1_CLR 0
`define PTC_C0_MASK 8'hF8
`define PTC_IRQ_A 0
`define PTC_IRQ_P 1
`define PTC_IRQ_MASK_BITS 8'h03
`define PTC_DIV4 2'h3
`define PTC_DIV16 4'hF
`define PTC_DIV64 6'h3F
`define PTC_DIV_SUB 8'hFF
`endif

// File: verilog/ptc_pkg.sv
// Purpose: types for the periodic timer core
// Assumes: nothing
// Notes: mode codes follow the two-bit mode field
package ptc_pkg;
  typedef enum logic [1:0] {
    PTC_MODE_CMP = 2'h0,
    PTC_MODE_UNDEF = 2'h1,
    PTC_MODE_PULSE = 2'h2,
    PTC_MODE_TIMER = 2'h3
  } ptc_mode_t;
  typedef enum logic [2:0] {
    PTC_CK_SYS4 = 3'h0,
    PTC_CK_SYS = 3'h1,
    PTC_CK_H16 = 3'h2,
    PTC_CK_H64 = 3'h3,
    PTC_CK_SUB0 = 3'h4,
    PTC_CK_SUB1 = 3'h5,
    PTC_CK_EXT_RISE = 3'h6,
    PTC_CK_EXT_FALL = 3'h7
  } ptc_clk_t;
  typedef enum logic [2:0] {
    PTC_WR_IDLE = 3'b001,
    PTC_WR_RESP = 3'b010,
    PTC_WR_UNUSED = 3'b100
  } ptc_wr_t;
endpackage

// File: verilog/ptc_timer.sv
// Purpose: periodic timer core with AXI4-Lite registers and interrupt
// Assumes: one clock aclk; slower count rates are enable pulses
// Notes: CNT_W is 10 for instances 0/1 and 16 for instances 2/3
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "ptc_params.svh"
module ptc_timer #(
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_input,
  input wire logic sub_clk_tick,
  output logic timer_output_pin,
  output logic timer_output_en,
  output logic irq
);
  import ptc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_p;
    logic [1:0] stat;
    logic [1:0] mask;
    logic run_d;
    logic out_lvl;
    logic [1:0] ext_sync;
    logic ext_d;
    logic [5:0] div;
    ptc_wr_t wst;
    logic [7:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ptc_state_t;

  ptc_state_t state_reg;
  ptc_state_t state_next;

  logic run;
  logic hold;
  ptc_clk_t clk_sel;
  ptc_mode_t mode;
  logic [1:0] pin_act;
  logic tick;
  logic run_rise;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clear_cnt;
  logic ev_a;
  logic ev_p;
  logic pwm_lvl;
  logic do_wr;
  logic [7:0] wbyte;
  logic [1:0] w1c;
  logic addr_ok;

  function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] v,
                                                input logic hi, input logic [7:0] b);
    logic [15:0] t;
    t = 16'h0000;
    t[CNT_W-1:0] = v;
    if (hi) begin
      t[15:8] = b;
    end else begin
      t[7:0] = b;
    end
    return t[CNT_W-1:0];
  endfunction

  function automatic logic [7:0] get_byte(input logic [CNT_W-1:0] v, input logic hi);
    logic [15:0] t;
    t = 16'h0000;
    t[CNT_W-1:0] = v;
    return hi ? t[15:8] : t[7:0];
  endfunction

  always_comb begin
    state_next = state_reg;
    run = state_reg.ctrl0[`PTC_C0_RUN];
    hold = state_reg.ctrl0[`PTC_C0_HOLD];
    clk_sel = ptc_clk_t'(state_reg.ctrl0[`PTC_C0_CLK_HI:`PTC_C0_CLK_LO]);
    mode = ptc_mode_t'(state_reg.ctrl1[`PTC_C1_MODE_HI:`PTC_C1_MODE_LO]);
    pin_act = state_reg.ctrl1[`PTC_C1_PIN_HI:`PTC_C1_PIN_LO];
    run_rise = run && !state_reg.run_d;
    // External pin passes two flip-flops before edge detection
    state_next.ext_sync = {state_reg.ext_sync[0], ext_count_input};
    state_next.ext_d = state_reg.ext_sync[1];
    state_next.div = 6'(state_reg.div + 6'h01);
    state_next.run_d = run;
    tick = 1'b0;
    unique case (clk_sel)
      PTC_CK_SYS4: tick = (state_reg.div[1:0] == `PTC_DIV4);
      PTC_CK_SYS: tick = 1'b1;
      PTC_CK_H16: tick = (state_reg.div[3:0] == `PTC_DIV16);
      PTC_CK_H64: tick = (state_reg.div == `PTC_DIV64);
      PTC_CK_SUB0, PTC_CK_SUB1: tick = sub_clk_tick;
      PTC_CK_EXT_RISE: tick = state_reg.ext_sync[1] && !state_reg.ext_d;
      PTC_CK_EXT_FALL: tick = !state_reg.ext_sync[1] && state_reg.ext_d;
    endcase
    // Comparators look at every counter bit
    match_a = (state_reg.count == state_reg.cmp_a);
    match_p = (state_reg.count == state_reg.cmp_p);
    overflow = &state_reg.count;
    ev_a = 1'b0;
    ev_p = 1'b0;
    clear_cnt = 1'b0;
    if (run && !run_rise && !hold && tick) begin
      ev_a = match_a;
      ev_p = match_p;
      if (mode == PTC_MODE_PULSE && pin_act == 2'h3) begin
        // Single pulse: compare A gives a one-cycle pulse and stops the timer
        if (match_a) begin
          state_next.ctrl0[`PTC_C0_RUN] = 1'b0;
        end
        ev_p = 1'b0;
      end else if (mode == PTC_MODE_PULSE) begin
        clear_cnt = match_p || overflow;
      end else if (state_reg.ctrl1[`PTC_C1_CLR]) begin
        clear_cnt = match_a || overflow;
        ev_p = 1'b0;
      end else begin
        clear_cnt = match_p || overflow;
      end
      if (clear_cnt) begin
        state_next.count = '0;
      end else if (!(mode == PTC_MODE_PULSE && pin_act == 2'h3 && match_a)) begin
        state_next.count = CNT_W'(state_reg.count + 1'b1);
      end
    end
    if (run_rise) begin
      state_next.count = '0;
      state_next.out_lvl = state_reg.ctrl1[`PTC_C1_INIT];
    end else if (ev_a && mode == PTC_MODE_CMP) begin
      unique case (pin_act)
        2'h0: state_next.out_lvl = state_reg.out_lvl;
        2'h1: state_next.out_lvl = 1'b0;
        2'h2: state_next.out_lvl = 1'b1;
        2'h3: state_next.out_lvl = !state_reg.out_lvl;
      endcase
    end else if (ev_a && mode == PTC_MODE_PULSE && pin_act == 2'h3) begin
      state_next.out_lvl = !state_reg.ctrl1[`PTC_C1_INIT];
    end else if (mode == PTC_MODE_PULSE && pin_act == 2'h3 && !run) begin
      state_next.out_lvl = state_reg.ctrl1[`PTC_C1_INIT];
    end
    // Pulse mode: active while counter below compare A
    pwm_lvl = (state_reg.count < state_reg.cmp_a) ? !state_reg.ctrl1[`PTC_C1_INIT]
                                                  : state_reg.ctrl1[`PTC_C1_INIT];

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !state_reg.aw_have && state_reg.wst == PTC_WR_IDLE) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_have && state_reg.wst == PTC_WR_IDLE) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    do_wr = state_reg.aw_have && state_reg.w_have && state_reg.wst == PTC_WR_IDLE;
    wbyte = state_reg.w_data[7:0];
    addr_ok = 1'b0;
    w1c = 2'h0;
    if (do_wr) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.wst = PTC_WR_RESP;
      addr_ok = 1'b1;
      if (state_reg.w_strb[0]) begin
        unique case (state_reg.aw_addr)
          `PTC_OFF_CTRL0: state_next.ctrl0 = wbyte & `PTC_C0_MASK;
          `PTC_OFF_CTRL1: state_next.ctrl1 = wbyte;
          `PTC_OFF_CNT_LO, `PTC_OFF_CNT_HI: addr_ok = 1'b1;
          `PTC_OFF_CMPA_LO: state_next.cmp_a = put_byte(state_reg.cmp_a, 1'b0, wbyte);
          `PTC_OFF_CMPA_HI: state_next.cmp_a = put_byte(state_reg.cmp_a, 1'b1, wbyte);
          `PTC_OFF_CMPP_LO: state_next.cmp_p = put_byte(state_reg.cmp_p, 1'b0, wbyte);
          `PTC_OFF_CMPP_HI: state_next.cmp_p = put_byte(state_reg.cmp_p, 1'b1, wbyte);
          `PTC_OFF_IRQ_STAT: w1c = wbyte[1:0];
          `PTC_OFF_IRQ_MASK: state_next.mask = wbyte[1:0];
          default: addr_ok = 1'b0;
        endcase
      end else begin
        unique case (state_reg.aw_addr)
          `PTC_OFF_CTRL0, `PTC_OFF_CTRL1, `PTC_OFF_CNT_LO, `PTC_OFF_CNT_HI,
          `PTC_OFF_CMPA_LO, `PTC_OFF_CMPA_HI, `PTC_OFF_CMPP_LO, `PTC_OFF_CMPP_HI,
          `PTC_OFF_IRQ_STAT, `PTC_OFF_IRQ_MASK: addr_ok = 1'b1;
          default: addr_ok = 1'b0;
        endcase
      end
      state_next.bresp = addr_ok ? 2'h0 : 2'h2;
    end
    if (state_reg.wst == PTC_WR_RESP && s_axi_bready) begin
      state_next.wst = PTC_WR_IDLE;
    end
    // Sticky flags: a new event wins over a same-cycle clear
    state_next.stat = (state_reg.stat & ~w1c) | {ev_p, ev_a};

    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = 2'h0;
      state_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        `PTC_OFF_CTRL0: state_next.rdata[7:0] = state_reg.ctrl0;
        `PTC_OFF_CTRL1: state_next.rdata[7:0] = state_reg.ctrl1;
        `PTC_OFF_CNT_LO: state_next.rdata[7:0] = get_byte(state_reg.count, 1'b0);
        `PTC_OFF_CNT_HI: state_next.rdata[7:0] = get_byte(state_reg.count, 1'b1);
        `PTC_OFF_CMPA_LO: state_next.rdata[7:0] = get_byte(state_reg.cmp_a, 1'b0);
        `PTC_OFF_CMPA_HI: state_next.rdata[7:0] = get_byte(state_reg.cmp_a, 1'b1);
        `PTC_OFF_CMPP_LO: state_next.rdata[7:0] = get_byte(state_reg.cmp_p, 1'b0);
        `PTC_OFF_CMPP_HI: state_next.rdata[7:0] = get_byte(state_reg.cmp_p, 1'b1);
        `PTC_OFF_IRQ_STAT: state_next.rdata[1:0] = state_reg.stat;
        `PTC_OFF_IRQ_MASK: state_next.rdata[1:0] = state_reg.mask;
        default: state_next.rresp = 2'h2;
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.wst <= PTC_WR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    s_axi_awready = !state_reg.aw_have && state_reg.wst == PTC_WR_IDLE;
    s_axi_wready = !state_reg.w_have && state_reg.wst == PTC_WR_IDLE;
    s_axi_bvalid = state_reg.wst == PTC_WR_RESP;
    s_axi_bresp = state_reg.bresp;
    s_axi_arready = !state_reg.rvalid;
    s_axi_rvalid = state_reg.rvalid;
    s_axi_rdata = state_reg.rdata;
    s_axi_rresp = state_reg.rresp;
    irq = |(state_reg.stat & state_reg.mask);
    timer_output_en = (mode != PTC_MODE_TIMER) && (mode != PTC_MODE_UNDEF);
    if (mode == PTC_MODE_PULSE && pin_act == 2'h2) begin
      timer_output_pin = pwm_lvl ^ state_reg.ctrl1[`PTC_C1_INV];
    end else if (mode == PTC_MODE_PULSE && pin_act == 2'h0) begin
      timer_output_pin = state_reg.ctrl1[`PTC_C1_INIT] ^ state_reg.ctrl1[`PTC_C1_INV];
    end else if (mode == PTC_MODE_PULSE && pin_act == 2'h1) begin
      timer_output_pin = !state_reg.ctrl1[`PTC_C1_INIT] ^ state_reg.ctrl1[`PTC_C1_INV];
    end else begin
      timer_output_pin = state_reg.out_lvl ^ state_reg.ctrl1[`PTC_C1_INV];
    end
  end
endmodule

// File: tb/ptc_timer_chk.sv
// Purpose: bus handshake and reset checks for the periodic timer core
// Assumes: bound to ptc_timer, single clock aclk
// Notes: sees top-level ports only
`timescale 1ns/100ps
module ptc_timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_rresp_codes: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
    else $error("bad read response code");
  a_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready &&
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("not idle after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule
bind ptc_timer ptc_timer_chk ptc_timer_chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .irq(irq));

// File: tb/ptc_pin_model.sv
// Purpose: far-side model driving the count pin and sub clock tick
// Assumes: burst is called just after a rising edge
// Notes: count pin idles low between pulses
`timescale 1ns/100ps
module ptc_pin_model (
  input wire logic aclk,
  input wire logic timer_output_pin,
  output logic ext_count_input,
  output logic sub_clk_tick
);
  initial begin
    ext_count_input = 1'b0;
    sub_clk_tick = 1'b0;
  end
  // One rise, one fall and one tick per unit
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_count_input <= 1'b1;
      sub_clk_tick <= 1'b1;
      @(posedge aclk);
      sub_clk_tick <= 1'b0;
      repeat (3) @(posedge aclk);
      ext_count_input <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule

// File: tb/ptc_timer_bench.sv
// Purpose: register-level bench for the periodic timer core
// Assumes: AXI4-Lite master with bready and rready held high
// Notes: 16-bit instance, plus a 10-bit instance whose read data is checked
`timescale 1ns/100ps
`include "ptc_params.svh"
module ptc_timer_bench;
  import ptc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd_d, r1, rd10;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdata10;
  logic [1:0] wb;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_en, irq, ext, tick;
  logic [1:0] bresp, rresp, rd_r;
  int num_errors = 0, n_tests = 0, cyc = 0;
  ptc_clk_t sel_tab [3] = '{PTC_CK_EXT_RISE, PTC_CK_EXT_FALL, PTC_CK_SUB0};
  ptc_timer #(.CNT_W(16)) ptc_timer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .ext_count_input(ext), .sub_clk_tick(tick), .timer_output_pin(pin),
    .timer_output_en(pin_en), .irq(irq));
  // Narrow instance shares the bus requests; only its read data is watched
  ptc_timer #(.CNT_W(10)) ptc_timer_10_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata10), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b1),
    .ext_count_input(ext), .sub_clk_tick(tick), .timer_output_pin(),
    .timer_output_en(), .irq());
  ptc_pin_model ptc_pin_model_i (.aclk(aclk), .timer_output_pin(pin),
    .ext_count_input(ext), .sub_clk_tick(tick));
  initial forever #2.5 aclk = ~aclk;
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wb = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    rd10 = rdata10[7:0];
    r = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    rd(a, rd_d, rd_r);
    chk($sformatf("rresp_%h", a), {6'h00, er}, {6'h00, rd_r});
    if (er == 2'h0) chk($sformatf("rdata_%h", a), e, rd_d);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`PTC_OFF_CNT_LO, 8'h00, 2'h0);
    rc(`PTC_OFF_CNT_HI, 8'h00, 2'h0);
    chk("cnt_hi_10bit", 8'h00, rd10);
    rc(`PTC_OFF_CMPA_LO, 8'h00, 2'h0);
    wr(`PTC_OFF_CMPA_LO, 8'h05);
    wr(`PTC_OFF_CMPP_LO, 8'h09);
    wr(`PTC_OFF_CMPP_HI, 8'hA5);
    rc(`PTC_OFF_CMPP_HI, 8'hA5, 2'h0);
    chk("cmpp_hi_10bit", 8'h01, rd10);
    wr(`PTC_OFF_CMPA_HI, 8'hFE);
    rc(`PTC_OFF_CMPA_HI, 8'hFE, 2'h0);
    chk("cmpa_hi_10bit", 8'h02, rd10);
    wr(`PTC_OFF_CMPA_HI, 8'h00);
    wr(`PTC_OFF_CMPP_HI, 8'h00);
    rc(`PTC_OFF_CMPA_LO, 8'h05, 2'h0);
    wr(`PTC_OFF_CNT_LO, 8'hFF);
    chk("bresp_cnt", 8'h00, {6'h00, wb});
    wr(8'h30, 8'h00);
    chk("bresp_unmapped", 8'h02, {6'h00, wb});
    rc(`PTC_OFF_CNT_LO, 8'h00, 2'h0);
    rc(8'h30, 8'h00, 2'h2);
    wr(`PTC_OFF_IRQ_MASK, `PTC_IRQ_MASK_BITS);
    wr(`PTC_OFF_CTRL1, 8'h08);
    wr(`PTC_OFF_CTRL0, 8'h98);
    repeat (2) @(posedge aclk);
    chk("pin", 8'h01, {7'h00, pin});
    chk("pin_en", 8'h01, {7'h00, pin_en});
    repeat (10) @(posedge aclk);
    rc(`PTC_OFF_CNT_LO, 8'h00, 2'h0);
    wr(`PTC_OFF_CTRL0, 8'h18);
    repeat (40) @(posedge aclk);
    wr(`PTC_OFF_CTRL0, 8'h10);
    rd(`PTC_OFF_CNT_LO, r1, rd_r);
    repeat (5) @(posedge aclk);
    rc(`PTC_OFF_CNT_LO, r1, 2'h0);
    chk("cnt_range", 8'h01, {7'h00, r1 <= 8'h09});
    rc(`PTC_OFF_IRQ_STAT, 8'h03, 2'h0);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`PTC_OFF_IRQ_MASK, 8'h00);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(`PTC_OFF_IRQ_MASK, `PTC_IRQ_MASK_BITS);
    chk("irq_unmasked", 8'h01, {7'h00, irq});
    wr(`PTC_OFF_IRQ_STAT, 8'h03);
    chk("irq_cleared", 8'h00, {7'h00, irq});
    wr(`PTC_OFF_CTRL1, {PTC_MODE_TIMER, 6'h00});
    chk("pin_en", 8'h00, {7'h00, pin_en});
    foreach (sel_tab[i]) begin
      wr(`PTC_OFF_CTRL0, 8'h00);
      wr(`PTC_OFF_CTRL0, {1'b0, sel_tab[i], 4'h8});
      ptc_pin_model_i.burst(3);
      repeat (10) @(posedge aclk);
      rc(`PTC_OFF_CNT_LO, 8'h03, 2'h0);
    end
    report_and_stop;
  end
endmodule
